// *** core/rcf_pkg.sv ***
// constants and register map of the respiration carrier select block
package rcf_pkg;

    // ************************************************************
    // clock
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam longint CLK_HZ = 64'd1000000000 / CLK_PERIOD_NS;
    localparam int ACC_W = 32;

    // phase increment of a 32-bit accumulator for a tone in hertz
    function automatic logic [ACC_W-1:0] rcf_inc(input longint hz);
        rcf_inc = ACC_W'((hz <<< ACC_W) / CLK_HZ);
    endfunction

    // ************************************************************
    // carrier frequencies in hertz
    // ************************************************************
    localparam longint F_64000_HZ = 64000;
    localparam longint F_56900_HZ = 56900;
    localparam longint F_56000_HZ = 56000;
    localparam longint F_54000_HZ = 54000;
    localparam longint F_52000_HZ = 52000;
    localparam longint F_51200_HZ = 51200;
    localparam longint F_50000_HZ = 50000;
    localparam longint F_46500_HZ = 46500;
    localparam longint F_32000_HZ = 32000;
    localparam longint F_28000_HZ = 28000;
    localparam longint F_25500_HZ = 25500;
    localparam longint F_23000_HZ = 23000;

    // increments indexed by carrier_freq_code
    localparam logic [ACC_W-1:0] INC_BASE [4] = '{rcf_inc(F_56000_HZ),
        rcf_inc(F_54000_HZ), rcf_inc(F_52000_HZ), rcf_inc(F_50000_HZ)};
    localparam logic [ACC_W-1:0] INC_ALT_HP [4] = '{rcf_inc(F_64000_HZ),
        rcf_inc(F_56900_HZ), rcf_inc(F_51200_HZ), rcf_inc(F_46500_HZ)};
    localparam logic [ACC_W-1:0] INC_ALT_LP [4] = '{rcf_inc(F_32000_HZ),
        rcf_inc(F_28000_HZ), rcf_inc(F_25500_HZ), rcf_inc(F_23000_HZ)};
    localparam logic [ACC_W-1:0] INC_SYNC_HP [4] = '{rcf_inc(F_64000_HZ),
        rcf_inc(F_56000_HZ), rcf_inc(F_51200_HZ), rcf_inc(F_46500_HZ)};
    localparam logic [ACC_W-1:0] INC_SYNC_FIX = rcf_inc(F_64000_HZ);

    // ************************************************************
    // register map: byte address is four times the index
    // ************************************************************
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_FRONT_END = 8'h01;
    localparam logic [7:0] IDX_RESP_CTRL = 8'h03;
    localparam logic [7:0] IDX_SWITCH = 8'h30;
    localparam logic [7:0] IDX_STATUS = 8'h31;
    localparam logic [7:0] IDX_DEMOD = 8'h32;

    // front_end_control_reg fields
    localparam int FE_HP_BIT = 3;
    localparam logic [31:0] FE_MASK = 32'h0000_0008;
    localparam logic [31:0] FE_RESET = 32'h0000_0000;

    // resp_control_reg fields
    localparam int RC_FREQ_LSB = 1;
    localparam int RC_ALT_BIT = 3;
    localparam int RC_SYNC_FLAG_BIT = 4;
    localparam int RC_SYNC_SEL_BIT = 7;
    localparam int RC_PATH_LSB = 8;
    localparam logic [31:0] RC_MASK = 32'h0000_039e;
    localparam logic [31:0] RC_RESET = 32'h0000_0000;

    // switch register fields
    localparam int SW_A_BIT = 0;
    localparam int SW_B_BIT = 1;
    localparam int SW_C_BIT = 2;
    localparam logic [31:0] SW_MASK = 32'h0000_0007;
    localparam logic [31:0] SW_RESET = 32'h0000_0000;

    // status register fields
    localparam int ST_CARRIER_BIT = 0;
    localparam int ST_SYNC_BIT = 1;

    localparam int SAMPLE_W = 16;
endpackage

// *** core/rcf_nco.sv ***
// phase accumulator that adopts a new increment on the first cycle after reset, then only at a period wrap
`timescale 1ns/100ps
module rcf_nco
    import rcf_pkg::*;
(
    input wire logic clock_i,                // system clock
    input wire logic rst_n_i,                // sync reset, active low
    input wire logic [ACC_W-1:0] inc_i,      // requested increment
    output logic wave_o,                     // square wave, msb of phase
    output logic wrap_o                      // one-cycle period boundary
);
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] inc_reg;
    logic loaded_reg;
    logic [ACC_W:0] sum_w;
    logic carry_w;

    assign sum_w = {1'b0, acc_reg} + {1'b0, inc_reg};
    assign carry_w = sum_w[ACC_W];

    // after the first load, increment only changes at the boundary so no period is cut short
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            acc_reg <= '0;
            inc_reg <= '0;
            loaded_reg <= 1'b0;
            wrap_o <= 1'b0;
            wave_o <= 1'b0;
        end else begin
            acc_reg <= sum_w[ACC_W-1:0];
            wave_o <= sum_w[ACC_W-1];
            wrap_o <= carry_w;
            loaded_reg <= 1'b1;
            if (carry_w || !loaded_reg) begin
                inc_reg <= inc_i;
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_inc_held_between: assert property (
        (loaded_reg && !carry_w) |=> $stable(inc_reg))
        else $error("increment changed inside a carrier period");
    a_inc_taken_wrap: assert property (
        (loaded_reg && carry_w) |=> inc_reg == $past(inc_i))
        else $error("increment not taken at period boundary");
endmodule // rcf_nco

// *** core/rcf_resp_carrier.sv ***
// respiration carrier select, sync pin, path switches and demodulator
// Summary of operation
// - alt bit clear: carrier 56, 54, 52 or 50 kHz by code.
// - alt set, sync off, high-perf set: 64, 56.9, 51.2, 46.5 kHz.
// - alt set, high-perf clear: 32, 28, 25.5, 23 kHz; sync ignored.
// - sync select bit 7 set drives the sync tone on sync pin.
// - sync flag on with alt clear puts 64 kHz on sync pin.
// - sync flag on with alt set: table of frequencies on sync pin.
// - extension switches route external respiration inputs to ECG channels.
// - each of three switches is set by software, never overridden.
// - digitized respiration signal demodulated against the selected carrier.
// - only one lead or external path measured at a time.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module rcf_resp_carrier
    import rcf_pkg::*;
(
    input wire logic clock_i,                     // 10 MHz system clock
    input wire logic rst_n_i,                     // sync reset, active low
    input wire logic [ADDR_W-1:0] avs_address_i,  // byte address
    input wire logic avs_read_i,                  // read request
    input wire logic avs_write_i,                 // write request
    input wire logic [31:0] avs_writedata_i,      // write data
    input wire logic [3:0] avs_byteenable_i,      // byte lanes
    output logic [31:0] avs_readdata_o,           // read data
    output logic avs_waitrequest_o,               // stall
    input wire logic [SAMPLE_W-1:0] adc_sample_i, // respiration sample
    input wire logic adc_valid_i,                 // sample strobe
    output logic carrier_o,                       // internal carrier
    output logic carrier_period_o,                // carrier boundary pulse
    output logic sync_output_pin_o,               // sync pin level
    output logic sync_output_pin_oe_o,            // sync pin drive enable
    output logic [3:0] resp_path_sel_o,           // one-hot measured path
    output logic path_switch_a_o,                 // extension switch a
    output logic path_switch_b_o,                 // extension switch b
    output logic path_switch_c_o,                 // extension switch c
    output logic [31:0] demod_o,                  // demodulated sum
    output logic demod_valid_o                    // new demod result
);

    // ************************************************************
    // bus slave
    // ************************************************************
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] fe_ctrl_reg;
    logic [31:0] resp_ctrl_reg;
    logic [31:0] switch_reg;
    logic [31:0] demod_reg;
    logic demod_valid_reg;

    wire req_w = avs_read_i | avs_write_i;
    wire [7:0] idx_w = avs_address_i[ADDR_W-1:2];
    wire wr_take_w = avs_write_i & ack_reg;
    wire sel_fe_w = (idx_w == IDX_FRONT_END);
    wire sel_rc_w = (idx_w == IDX_RESP_CTRL);
    wire sel_sw_w = (idx_w == IDX_SWITCH);
    wire sel_st_w = (idx_w == IDX_STATUS);
    wire sel_dm_w = (idx_w == IDX_DEMOD);
    logic [31:0] lane_mask_w;
    logic [31:0] rd_mux_w;

    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign lane_mask_w[lane*8 +: 8] = {8{avs_byteenable_i[lane]}};
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] wd, input logic [31:0] lm,
            input logic [31:0] fm);
        merge = ((old & ~lm) | (wd & lm)) & fm;
    endfunction

    // exactly one wait cycle on every access
    assign avs_waitrequest_o = req_w & ~ack_reg;
    assign avs_readdata_o = rdata_reg;

    // unmapped addresses read zero, writes to them are dropped
    assign rd_mux_w = sel_fe_w ? fe_ctrl_reg :
                      sel_rc_w ? resp_ctrl_reg :
                      sel_sw_w ? switch_reg :
                      sel_st_w ? {30'h0000_0000, sync_output_pin_o,
                                  carrier_o} :
                      sel_dm_w ? demod_reg : 32'h0000_0000;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req_w & ~ack_reg;
            if (req_w && !ack_reg) begin
                rdata_reg <= rd_mux_w;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            fe_ctrl_reg <= FE_RESET;
            resp_ctrl_reg <= RC_RESET;
            switch_reg <= SW_RESET;
        end else if (wr_take_w) begin
            if (sel_fe_w) begin
                fe_ctrl_reg <= merge(fe_ctrl_reg, avs_writedata_i,
                                     lane_mask_w, FE_MASK);
            end
            if (sel_rc_w) begin
                resp_ctrl_reg <= merge(resp_ctrl_reg, avs_writedata_i,
                                       lane_mask_w, RC_MASK);
            end
            if (sel_sw_w) begin
                switch_reg <= merge(switch_reg, avs_writedata_i,
                                    lane_mask_w, SW_MASK);
            end
        end
    end

    // ************************************************************
    // frequency selection
    // ************************************************************
    wire [1:0] code_w = resp_ctrl_reg[RC_FREQ_LSB +: 2];
    wire alt_carrier_select = resp_ctrl_reg[RC_ALT_BIT];
    wire carrier_sync_out_flag = resp_ctrl_reg[RC_SYNC_FLAG_BIT];
    wire carrier_sync_out_select = resp_ctrl_reg[RC_SYNC_SEL_BIT];
    wire high_perf_mode = fe_ctrl_reg[FE_HP_BIT];
    logic [ACC_W-1:0] carrier_inc_w;
    logic [ACC_W-1:0] sync_inc_w;
    logic carrier_wrap_w;

    assign carrier_inc_w = !alt_carrier_select ? INC_BASE[code_w] :
                           high_perf_mode ? INC_ALT_HP[code_w] :
                           INC_ALT_LP[code_w];

    // without the sync flag the pin mirrors the internal carrier tone
    assign sync_inc_w = !carrier_sync_out_flag ? carrier_inc_w :
                        !alt_carrier_select ? INC_SYNC_FIX :
                        high_perf_mode ? INC_SYNC_HP[code_w] :
                        INC_ALT_LP[code_w];

    rcf_nco u_carrier_nco (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .inc_i(carrier_inc_w),
        .wave_o(carrier_o),
        .wrap_o(carrier_wrap_w)
    );

    // separate accumulator: the sync tone may differ from the carrier
    rcf_nco u_sync_nco (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .inc_i(sync_inc_w),
        .wave_o(sync_output_pin_o),
        .wrap_o()
    );

    assign carrier_period_o = carrier_wrap_w;
    assign sync_output_pin_oe_o = carrier_sync_out_select;

    // ************************************************************
    // path selection and extension switches
    // ************************************************************
    wire [1:0] path_w = resp_ctrl_reg[RC_PATH_LSB +: 2];

    assign resp_path_sel_o = 4'h1 << path_w;
    assign path_switch_a_o = switch_reg[SW_A_BIT];
    assign path_switch_b_o = switch_reg[SW_B_BIT];
    assign path_switch_c_o = switch_reg[SW_C_BIT];

    // ************************************************************
    // synchronous demodulation
    // ************************************************************
    logic signed [31:0] sum_reg;
    wire signed [31:0] sample_w = 32'(signed'(adc_sample_i));
    wire signed [31:0] term_w = carrier_o ? sample_w : -sample_w;
    wire signed [31:0] sum_next = sum_reg + (adc_valid_i ? term_w : 32'sd0);

    // one result per carrier period keeps the sum bounded
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sum_reg <= 32'sd0;
            demod_reg <= 32'h0000_0000;
            demod_valid_reg <= 1'b0;
        end else begin
            demod_valid_reg <= carrier_wrap_w;
            if (carrier_wrap_w) begin
                demod_reg <= 32'(sum_next);
                sum_reg <= 32'sd0;
            end else begin
                sum_reg <= sum_next;
            end
        end
    end

    assign demod_o = demod_reg;
    assign demod_valid_o = demod_valid_reg;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_stalled;
        req_w && avs_waitrequest_o;
    endsequence
    sequence s_answered;
        !avs_waitrequest_o;
    endsequence

    a_bus_one_wait: assert property (s_stalled |=> s_answered)
        else $error("bus access not answered after one wait cycle");
    a_carrier_base_set: assert property (
        !alt_carrier_select |-> carrier_inc_w == INC_BASE[code_w])
        else $error("base carrier frequency wrong");
    a_carrier_alt_hp: assert property (
        (alt_carrier_select && high_perf_mode)
        |-> carrier_inc_w == INC_ALT_HP[code_w])
        else $error("high performance alternate carrier wrong");
    a_carrier_alt_lp: assert property (
        (alt_carrier_select && !high_perf_mode)
        |-> carrier_inc_w == INC_ALT_LP[code_w])
        else $error("low power alternate carrier wrong");
    a_sync_pin_enable: assert property (
        (wr_take_w && sel_rc_w && avs_byteenable_i[0]
         && avs_writedata_i[RC_SYNC_SEL_BIT]) |=> sync_output_pin_oe_o)
        else $error("sync pin not driven after select");
    a_sync_fixed_tone: assert property (
        (carrier_sync_out_flag && !alt_carrier_select)
        |-> sync_inc_w == INC_SYNC_FIX)
        else $error("sync tone not fixed with alternate off");
    a_sync_alt_tone: assert property (
        (carrier_sync_out_flag && alt_carrier_select)
        |-> sync_inc_w == (high_perf_mode ? INC_SYNC_HP[code_w]
                                          : INC_ALT_LP[code_w]))
        else $error("sync tone wrong with alternate on");
    a_switch_write: assert property (
        (wr_take_w && sel_sw_w && avs_byteenable_i[0])
        |=> {path_switch_c_o, path_switch_b_o, path_switch_a_o}
            == $past(avs_writedata_i[2:0]))
        else $error("switch state differs from write");
    a_one_path: assert property ($onehot(resp_path_sel_o))
        else $error("more than one respiration path selected");
    a_demod_update: assert property (
        carrier_wrap_w |=> demod_valid_o ##1 !demod_valid_o)
        else $error("demod result not posted at carrier boundary");
endmodule // rcf_resp_carrier

// *** tb/rcf_ext_gen.sv ***
// sync pin follower standing in for the external carrier generator
`timescale 1ns/100ps
module rcf_ext_gen (
    input wire logic clock_i, // system clock
    input wire logic rst_n_i, // sync reset, active low
    input wire logic pin_i,   // sync pin level as seen on the wire
    output int period_o       // cycles between rising edges, 0 unlocked
);
    int count;
    logic last;
    // locks to whatever tone the pin carries
    always @(posedge clock_i) begin
        last <= pin_i;
        if (!rst_n_i) begin
            count <= 0;
            period_o <= 0;
        end else if (pin_i && !last) begin
            // first edge only starts the count, no period yet
            if (count != 0) period_o <= count;
            count <= 1;
        end else if (count != 0) begin
            count <= count + 1;
        end
    end
endmodule // rcf_ext_gen

// *** tb/rcf_resp_carrier_test.sv ***
// self-checking bench of the respiration carrier select block
`timescale 1ns/100ps
module rcf_resp_carrier_test;
    import rcf_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [SAMPLE_W-1:0] sample = '0;
    logic valid = 1'b0;
    logic [31:0] rdata, demod;
    logic wait_req, carrier, cperiod, pin, pin_oe, sw_a, sw_b, sw_c, dvalid;
    logic [3:0] path_sel;
    logic toggle = 1'b0;
    logic sync_wire;
    int ext_period;
    int failures = 0;
    int cmp_count = 0;
    int since = 0;
    int t_base[4] = '{56000, 54000, 52000, 50000};
    int t_hp[4] = '{64000, 56900, 51200, 46500};
    int t_lp[4] = '{32000, 28000, 25500, 23000};
    int t_shp[4] = '{64000, 56000, 51200, 46500};
    int f_q[$];

    rcf_resp_carrier rcf_resp_carrier_inst (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_req), .adc_sample_i(sample),
        .adc_valid_i(valid), .carrier_o(carrier),
        .carrier_period_o(cperiod), .sync_output_pin_o(pin),
        .sync_output_pin_oe_o(pin_oe), .resp_path_sel_o(path_sel),
        .path_switch_a_o(sw_a), .path_switch_b_o(sw_b),
        .path_switch_c_o(sw_c), .demod_o(demod), .demod_valid_o(dvalid));
    rcf_ext_gen rcf_ext_gen_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .pin_i(sync_wire), .period_o(ext_period));

    // released pin shows a changing pattern, not its last level
    assign sync_wire = pin_oe ? pin : toggle;
    initial forever #50 clock_i = ~clock_i;
    always @(posedge clock_i) toggle <= ~toggle;
    always @(posedge clock_i) since <= (cperiod === 1'b1) ? 1 : since + 1;

    // ************************************************************
    // reference model and helpers
    // ************************************************************
    function automatic int carrier_hz(int alt, int hp, int code);
        return alt == 0 ? t_base[code] : (hp != 0 ? t_hp[code] : t_lp[code]);
    endfunction
    function automatic int sync_hz(int alt, int hp, int sy, int code);
        if (sy == 0) return carrier_hz(alt, hp, code);
        return alt == 0 ? 64000 : (hp != 0 ? t_shp[code] : t_lp[code]);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // nco truncation stretches a period by at most two cycles
    task automatic check_per(input int got, input int hz);
        int exp;
        exp = 10000000 / hz;
        cmp_count++;
        if (got < exp || got > exp + 2) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clock_i);
            n++;
        end while (wait_req !== 1'b0 && n < 100);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 100) check(32'h0, 32'h1);
        @(posedge clock_i);
    endtask
    task automatic wait_pulse();
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (cperiod !== 1'b1 && n < 2000);
        if (n >= 2000) check(32'h0, 32'h1);
    endtask
    task automatic give_verdict();
        $display("%0d mismatches in %0d comparisons", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (100000) @(posedge clock_i);
        $display("Error at %0t: watchdog expired", $time);
        failures++;
        give_verdict();
    end
    initial begin
        logic [31:0] q, rcw;
        int alt, hp, sy, code, sel, path, sw, d;
        void'($urandom(32'h71bb423d));
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        f_q.delete();
        bus(1'b0, 10'h004, 32'h0, q); check(q, 32'h0);
        bus(1'b0, 10'h00c, 32'h0, q); check(q, 32'h0);
        bus(1'b0, 10'h0c0, 32'h0, q); check(q, 32'h0);
        check(path_sel, 4'b0001);
        bus(1'b1, 10'h3fc, $urandom, q);
        bus(1'b0, 10'h3fc, 32'h0, q); check(q, 32'h0);
        $display("reset and map test done");
        f_q.push_back(t_base[0]);
        for (int i = 0; i < 32; i++) begin
            // int targets: a packed concatenation would zero-extend
            alt = (i >> 4) & 1;
            hp = (i >> 3) & 1;
            sy = (i >> 2) & 1;
            code = i & 3;
            sel = $urandom % 2;
            path = $urandom % 4;
            sw = $urandom % 8;
            f_q.push_back(carrier_hz(alt, hp, code));
            wait_pulse();
            bus(1'b1, 10'h004, ($urandom & ~FE_MASK) | (hp << FE_HP_BIT), q);
            rcw = ($urandom & ~RC_MASK) | (code << RC_FREQ_LSB) |
                (alt << RC_ALT_BIT) | (sy << RC_SYNC_FLAG_BIT) |
                (sel << RC_SYNC_SEL_BIT) | (path << RC_PATH_LSB);
            bus(1'b1, 10'h00c, rcw, q);
            bus(1'b1, 10'h0c0, ($urandom & ~SW_MASK) | sw, q);
            valid <= 1'(($urandom % 2));
            sample <= SAMPLE_W'(($urandom % 256) + 1);
            bus(1'b0, 10'h00c, 32'h0, q); check(q, rcw & RC_MASK);
            bus(1'b0, 10'h0c0, 32'h0, q); check(q, sw);
            check({sw_c, sw_b, sw_a}, sw);
            check(path_sel, 4'b0001 << path);
            check(pin_oe, sel);
            wait_pulse();
            check_per(since, f_q.pop_front());
            wait_pulse();
            check_per(since, f_q[0]);
            @(posedge clock_i);
            check(dvalid, 1'b1);
            d = $signed(demod);
            if (d < 0) d = -d;
            if (valid == 1'b0) check(demod, 32'h0);
            else check(d <= 4 * sample, 1'b1);
            rcw = demod;
            bus(1'b0, 10'h0c8, 32'h0, q); check(q, rcw);
            repeat (700) @(posedge clock_i);
            if (sel != 0) check_per(ext_period, sync_hz(alt, hp, sy, code));
            $display("carrier setting %0d test done", i);
        end
        give_verdict();
    end
endmodule // rcf_resp_carrier_test
